// ---- verilog/eq_strap_regs.sv ----
/*
 Equalizer test control register (per receive port) and strap mode status
 register. Assumes a decoded control bus request on sys_clk, and strap decode
 results with done flags from the strap sampler on the same clock.
*/
//Behaviour
//- Setting restart bit 6 restarts equalizer adaptation from its initial value.
//- Restart bit is not self clearing; hardware leaves it as software wrote it.
//- A restart request restarts adaptation on both receive ports.
//- Override enable bit 5 gates the floor-start bit; without it no effect.
//- Override plus floor-start bit 4 starts adaptation from preset floor value.
//- With second port selected, test register writes update the second port.
//- Status bit 7 reads 1 once back-channel strap decode is latched, else 0.
//- Back-channel codes: 5M SHIELDED_TWISTED_PAIR, 5M coax, 20M SHIELDED_TWISTED_PAIR, 20M coax; upper half repeats.
//- Status bit 3 reads 1 once output strap decode is latched, else 0.
//- Output codes: dual, dual swapped, single, replicated; upper half repeats.
//- Port select clear means first port registers are accessed at primary address.
`timescale 1ns/100ps
module eq_strap_regs
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire eq_strap_pkg::bus_req_t bus_req,
   input wire logic second_port_select,
   input wire logic bc_done,
   input wire logic [2:0] bc_code,
   input wire logic out_done,
   input wire logic [2:0] out_code,
   output logic [7:0] rdata,
   output eq_strap_pkg::eq_ctrl_t port0_ctrl,
   output eq_strap_pkg::eq_ctrl_t port1_ctrl,
   output logic restart_adapt,
   output logic port0_floor_start,
   output logic port1_floor_start,
   output logic [1:0] backchannel_mode,
   output logic [1:0] output_mode
);
   logic [7:0] reg0;
   logic [7:0] reg1;
   eq_strap_pkg::strap_status_t status;
   logic wr_eq;
   logic [7:0] next_rdata;

   assign wr_eq = bus_req.write && (bus_req.addr == eq_strap_pkg::ADDR_EQ_TEST);

   // Per-port storage, only defined bits kept
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reg0 <= eq_strap_pkg::EQ_TEST_RESET;
         reg1 <= eq_strap_pkg::EQ_TEST_RESET;
      end
      else if (wr_eq)
      begin
         if (second_port_select)
            reg1 <= bus_req.wdata & eq_strap_pkg::EQ_TEST_WMASK;
         else
            reg0 <= bus_req.wdata & eq_strap_pkg::EQ_TEST_WMASK;
      end
   end

   // Status latched from sampler; bus writes never reach it
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         status <= eq_strap_pkg::strap_status_t'(eq_strap_pkg::STRAP_STATUS_RESET);
      else
      begin
         if (bc_done && !status.backchannel_strap_latched)
         begin
            status.backchannel_strap_latched <= 1'b1;
            status.backchannel_strap_decode <= bc_code;
         end
         if (out_done && !status.output_strap_latched)
         begin
            status.output_strap_latched <= 1'b1;
            status.output_strap_decode <= out_code;
         end
      end
   end

   always_comb
   begin
      next_rdata = 8'h00;
      case (bus_req.addr)
         eq_strap_pkg::ADDR_EQ_TEST:
            next_rdata = second_port_select ? reg1 : reg0;
         eq_strap_pkg::ADDR_STRAP_STATUS:
            next_rdata = status;
         default:
            next_rdata = 8'h00;
      endcase
   end

   // Read data one cycle after the address
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata <= 8'h00;
      else
         rdata <= next_rdata;
   end

   // Per-port control images toward the equalizers
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         port0_ctrl <= '0;
         port1_ctrl <= '0;
      end
      else
      begin
         port0_ctrl <= {reg0[eq_strap_pkg::BIT_RESTART],
            reg0[eq_strap_pkg::BIT_FLOOR_OVERRIDE], reg0[eq_strap_pkg::BIT_FLOOR_START]};
         port1_ctrl <= {reg1[eq_strap_pkg::BIT_RESTART],
            reg1[eq_strap_pkg::BIT_FLOOR_OVERRIDE], reg1[eq_strap_pkg::BIT_FLOOR_START]};
      end
   end

   // Restart level shared by both equalizers
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         restart_adapt <= 1'b0;
      else
         restart_adapt <= reg0[eq_strap_pkg::BIT_RESTART]
            | reg1[eq_strap_pkg::BIT_RESTART];
   end

   // Floor start only where the override is also set
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         port0_floor_start <= 1'b0;
         port1_floor_start <= 1'b0;
      end
      else
      begin
         port0_floor_start <= reg0[eq_strap_pkg::BIT_FLOOR_OVERRIDE]
            & reg0[eq_strap_pkg::BIT_FLOOR_START];
         port1_floor_start <= reg1[eq_strap_pkg::BIT_FLOOR_OVERRIDE]
            & reg1[eq_strap_pkg::BIT_FLOOR_START];
      end
   end

   // Mode outputs; upper code bit only aliases
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         backchannel_mode <= 2'h0;
         output_mode <= 2'h0;
      end
      else
      begin
         backchannel_mode <= status.backchannel_strap_decode[1:0];
         output_mode <= status.output_strap_decode[1:0];
      end
   end

   sequence write_eq_s;
      wr_eq;
   endsequence

   restart_both_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg0[eq_strap_pkg::BIT_RESTART] || reg1[eq_strap_pkg::BIT_RESTART])
      |=> restart_adapt)
      else $error("restart not driven");
   restart_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !wr_eq |=> $stable(reg0) && $stable(reg1))
      else $error("register changed without write");
   floor_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !reg0[eq_strap_pkg::BIT_FLOOR_OVERRIDE] |=> !port0_floor_start)
      else $error("floor start without override");
   floor_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg1[eq_strap_pkg::BIT_FLOOR_OVERRIDE] && reg1[eq_strap_pkg::BIT_FLOOR_START])
      |=> port1_floor_start)
      else $error("floor start missing");
   port_steer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write_eq_s and second_port_select |=> $stable(reg0))
      else $error("port0 written while port1 selected");
   port0_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write_eq_s and !second_port_select
      |=> reg0 == ($past(bus_req.wdata) & eq_strap_pkg::EQ_TEST_WMASK))
      else $error("port0 write lost");
   bc_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bc_done |=> status.backchannel_strap_latched)
      else $error("back-channel done not latched");
   out_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (out_done && !status.output_strap_latched)
      |=> status.output_strap_decode == $past(out_code))
      else $error("output decode not latched");
   status_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_req.addr == eq_strap_pkg::ADDR_STRAP_STATUS |=> rdata == $past(status))
      else $error("status read wrong");
   bc_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ##1 backchannel_mode == $past(status.backchannel_strap_decode[1:0]))
      else $error("back-channel mode wrong");
   out_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ##1 output_mode == $past(status.output_strap_decode[1:0]))
      else $error("output mode wrong");
   reserved_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg0 & ~eq_strap_pkg::EQ_TEST_WMASK) == 8'h00)
      else $error("reserved bit set");
   restart_src_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !reg0[eq_strap_pkg::BIT_RESTART] && !reg1[eq_strap_pkg::BIT_RESTART]
      |=> !restart_adapt)
      else $error("spurious restart");

   sequence bc_take_s;
      bc_done && !status.backchannel_strap_latched;
   endsequence

   sequence out_take_s;
      out_done && !status.output_strap_latched;
   endsequence

   port1_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write_eq_s and second_port_select
      |=> reg1 == ($past(bus_req.wdata) & eq_strap_pkg::EQ_TEST_WMASK))
      else $error("port1 write lost");
   port_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      write_eq_s and !second_port_select |=> $stable(reg1))
      else $error("port1 written while port0 selected");
   reserved_port1_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg1 & ~eq_strap_pkg::EQ_TEST_WMASK) == 8'h00)
      else $error("reserved bit set on port1");
   bc_decode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bc_take_s |=> status.backchannel_strap_decode == $past(bc_code))
      else $error("back-channel decode not latched");
   bc_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      status.backchannel_strap_latched |=> status.backchannel_strap_latched
      && $stable(status.backchannel_strap_decode))
      else $error("back-channel decode changed after latch");
   out_latch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      out_take_s |=> status.output_strap_latched)
      else $error("output done not latched");
   out_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      status.output_strap_latched |=> status.output_strap_latched
      && $stable(status.output_strap_decode))
      else $error("output decode changed after latch");
   eq_read0_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_req.addr == eq_strap_pkg::ADDR_EQ_TEST && !second_port_select
      |=> rdata == $past(reg0))
      else $error("port0 read wrong");
   eq_read1_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_req.addr == eq_strap_pkg::ADDR_EQ_TEST && second_port_select
      |=> rdata == $past(reg1))
      else $error("port1 read wrong");
   unmapped_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_req.addr != eq_strap_pkg::ADDR_EQ_TEST
      && bus_req.addr != eq_strap_pkg::ADDR_STRAP_STATUS |=> rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

// ---- verilog/eq_strap_pkg.sv ----
/*
 Constants and carrier types for the equalizer test control and strap mode
 status registers. Assumes an 8-bit control bus with 8-bit register addresses.
*/
package eq_strap_pkg;
   localparam logic [7:0] ADDR_EQ_TEST = 8'h35;
   localparam logic [7:0] ADDR_STRAP_STATUS = 8'h37;
   localparam logic [7:0] EQ_TEST_RESET = 8'h00;
   localparam logic [7:0] STRAP_STATUS_RESET = 8'h00;
   localparam int BIT_RESTART = 6;
   localparam int BIT_FLOOR_OVERRIDE = 5;
   localparam int BIT_FLOOR_START = 4;
   localparam int BIT_BC_LATCHED = 7;
   localparam int BIT_OUT_LATCHED = 3;
   localparam logic [7:0] EQ_TEST_WMASK = 8'h70;
   // Back-channel decode meanings (codes 4..7 alias 0..3)
   localparam logic [1:0] BC_5M_STP = 2'h0;
   localparam logic [1:0] BC_5M_COAX = 2'h1;
   localparam logic [1:0] BC_20M_STP = 2'h2;
   localparam logic [1:0] BC_20M_COAX = 2'h3;
   // Output arrangement meanings (codes 4..7 alias 0..3)
   localparam logic [1:0] OUT_DUAL = 2'h0;
   localparam logic [1:0] OUT_DUAL_SWAP = 2'h1;
   localparam logic [1:0] OUT_SINGLE = 2'h2;
   localparam logic [1:0] OUT_REPLICATE = 2'h3;

   typedef struct packed {
      logic restart;
      logic floor_override_enable;
      logic floor_start_select;
   } eq_ctrl_t;

   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic backchannel_strap_latched;
      logic [2:0] backchannel_strap_decode;
      logic output_strap_latched;
      logic [2:0] output_strap_decode;
   } strap_status_t;
endpackage

// ---- verification/tb.sv ----
/*
 Self-checking bench for the equalizer test and strap status registers.
 Assumes the register block alone on sys_clk, driven directly by the bench.
*/
`timescale 1ns/100ps
module tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   eq_strap_pkg::bus_req_t bus_req = '0;
   logic sel = 1'b0, bc_done = 1'b0, out_done = 1'b0;
   logic [2:0] bc_code = 3'h0, out_code = 3'h0;
   logic [7:0] rdata, p0 = 8'h00, p1 = 8'h00, st = 8'h00, a, v;
   eq_strap_pkg::eq_ctrl_t port0_ctrl, port1_ctrl;
   logic restart_adapt, port0_floor_start, port1_floor_start;
   logic [1:0] backchannel_mode, output_mode;
   int n_mismatch = 0, check_count = 0;
   always #5 sys_clk = ~sys_clk;
   eq_strap_regs i_eq_strap_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .second_port_select(sel), .bc_done(bc_done), .bc_code(bc_code), .out_done(out_done),
      .out_code(out_code), .rdata(rdata), .port0_ctrl(port0_ctrl), .port1_ctrl(port1_ctrl),
      .restart_adapt(restart_adapt), .port0_floor_start(port0_floor_start),
      .port1_floor_start(port1_floor_start), .backchannel_mode(backchannel_mode),
      .output_mode(output_mode));
   function automatic logic [7:0] exp_rd(input logic [7:0] x);
      if (x == eq_strap_pkg::ADDR_EQ_TEST)
         return sel ? p1 : p0;
      if (x == eq_strap_pkg::ADDR_STRAP_STATUS)
         return st;
      return 8'h00;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] x, input logic [7:0] y);
      @(posedge sys_clk);
      bus_req <= '{1'b1, x, y};
      @(posedge sys_clk);
      bus_req.write <= 1'b0;
      if (x == eq_strap_pkg::ADDR_EQ_TEST && sel)
         p1 = y & eq_strap_pkg::EQ_TEST_WMASK;
      else if (x == eq_strap_pkg::ADDR_EQ_TEST)
         p0 = y & eq_strap_pkg::EQ_TEST_WMASK;
   endtask
   task automatic rd(input logic [7:0] x);
      @(posedge sys_clk);
      bus_req.addr <= x;
      @(posedge sys_clk);
      #1 chk("rdata", exp_rd(x), rdata);
   endtask
   task automatic outs();
      repeat (2) @(posedge sys_clk);
      #1 chk("port0", {5'h00, p0[6:4]}, {5'h00, port0_ctrl});
      chk("port1", {5'h00, p1[6:4]}, {5'h00, port1_ctrl});
      chk("restart", {7'h00, p0[6] | p1[6]}, {7'h00, restart_adapt});
      chk("floor0", {7'h00, p0[5] & p0[4]}, {7'h00, port0_floor_start});
      chk("floor1", {7'h00, p1[5] & p1[4]}, {7'h00, port1_floor_start});
   endtask
   task automatic strap(input logic [2:0] b, input logic [2:0] o, input logic bd, od);
      @(posedge sys_clk);
      bc_code <= b;
      out_code <= o;
      bc_done <= bd;
      out_done <= od;
      @(posedge sys_clk);
      bc_code <= ~b;
      out_code <= ~o;
      bc_done <= 1'b0;
      out_done <= 1'b0;
      if (bd && !st[7])
         st[7:4] = {1'b1, b};
      if (od && !st[3])
         st[3:0] = {1'b1, o};
      repeat (2) @(posedge sys_clk);
      #1 chk("bc_mode", {6'h00, st[5:4]}, {6'h00, backchannel_mode});
      chk("out_mode", {6'h00, st[1:0]}, {6'h00, output_mode});
      rd(eq_strap_pkg::ADDR_STRAP_STATUS);
   endtask
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      v = $urandom(5130);
      for (int i = 0; i < 8; i++)
      begin
         if (i > 0)
            @(posedge sys_clk);
         sys_rst <= 1'b1;
         repeat (10) @(posedge sys_clk);
         sys_rst <= 1'b0;
         p0 = 8'h00;
         p1 = 8'h00;
         st = 8'h00;
         rd(eq_strap_pkg::ADDR_STRAP_STATUS);
         rd(eq_strap_pkg::ADDR_EQ_TEST);
         outs();
         strap(3'(i), 3'(7 - i), 1'b0, 1'b1);
         strap(3'(7 - i), 3'(i), 1'b1, 1'b0);
         strap(3'($urandom), 3'($urandom), 1'b1, 1'b1);
         wr(eq_strap_pkg::ADDR_EQ_TEST, 8'($urandom));
      end
      wr(eq_strap_pkg::ADDR_EQ_TEST, 8'hFF);
      outs();
      wr(eq_strap_pkg::ADDR_EQ_TEST, 8'hBF);
      outs();
      for (int i = 0; i < 40; i++)
      begin
         @(posedge sys_clk);
         sel <= 1'($urandom);
         case ($urandom % 3)
            0: a = eq_strap_pkg::ADDR_EQ_TEST;
            1: a = eq_strap_pkg::ADDR_STRAP_STATUS;
            default: a = 8'($urandom);
         endcase
         wr(a, 8'($urandom));
         outs();
         rd(eq_strap_pkg::ADDR_EQ_TEST);
         rd(a);
      end
      complete_run();
   end
endmodule
